// file: core/gate_am_ctrl.sv
// Gated output and amplitude-modulation control with trigger generator.
// Assumes key and remote events are one-cycle pulses on clk; only the
// external gate pin is asynchronous.
// What this block does
// - Gate key toggles gated-output enable, indicated
// - Gate indicator blinks while gate editing
// - Gate source: external, manual/remote, or generator
// - Gate open passes waveform, else dc offset
// - Main waveform free-running, never resynchronised
// - External source: level-sensitive gate input
// - Manual source: each press flips gate
// - Generator source: gate open while square high
// - Programmable shared square-wave trigger generator
// - Unreachable periods round up to next step
// - Generator square wave on dedicated output
// - Report generator users, or free
// - Equivalent frequency derived, read-only
// - Modulation key toggles enable; blink in edit
// - Modulation source: external amplitude or generator
// - Depth accepts whole percent 1 to 100
// - Modulation waveform square default, or sine
// - Sine shows fixed period, keeps user period
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module gate_am_ctrl
	import gate_am_pkg::*;
#(
	parameter int unsigned BLINK_CYC = BLINK_CYC_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        gate_key_press,
	input  wire logic        am_key_press,
	input  wire logic        manual_trigger_key,
	input  wire logic        external_gate_input,
	input  wire logic        fsk_uses_internal_trigger_generator,
	input  wire logic        trig_uses_internal_trigger_generator,
	input  wire logic [11:0] main_wave,
	input  wire logic [11:0] dc_offset,
	output logic      [11:0] main_out,
	output logic             gate_indicator,
	output logic             am_indicator,
	output logic             trigger_generator_output,
	output logic             am_enable,
	output logic             am_internal,
	output logic             am_sine_select,
	output logic      [6:0]  modulation_depth_setting,
	output logic             am_square_mod
);

	// Configuration and control state
	logic        gate_en_q,   gate_en_d;
	logic        gate_edit_q, gate_edit_d;
	gate_src_e   gate_src_q,  gate_src_d;
	logic        man_gate_q,  man_gate_d;
	logic        am_en_q,     am_en_d;
	logic        am_edit_q,   am_edit_d;
	logic        am_int_q,    am_int_d;
	logic        am_sine_q,   am_sine_d;
	logic [6:0]  depth_q,     depth_d;
	logic [23:0] steps_q,     steps_d;
	logic [31:0] rdata_q,     rdata_d;
	// Generator, blink and output state
	logic [6:0]  pre_q,       pre_d;
	logic [23:0] half_q,      half_d;
	logic        internal_trigger_generator_q,      internal_trigger_generator_d;
	logic [23:0] blink_cnt_q, blink_cnt_d;
	logic        blink_q,     blink_d;
	logic        ext_s1_q,    ext_s2_q;
	logic [11:0] out_q,       out_d;
	logic        gind_q,      gind_d;
	logic        aind_q,      aind_d;
	logic [31:0] disp_q;
	// Combinational helpers
	logic        gate_key_ev, am_key_ev, man_ev, tick, gate_cond;
	logic [31:0] req_us, disp_period, freq_mhz;
	logic [4:0]  share;

	// Key events from front panel or remote writes
	assign gate_key_ev = gate_key_press
		| (wr && addr == KEY_OFS && wdata[KEY_GATE_BIT]);
	assign am_key_ev   = am_key_press
		| (wr && addr == KEY_OFS && wdata[KEY_AM_BIT]);
	assign man_ev      = manual_trigger_key
		| (wr && addr == KEY_OFS && wdata[KEY_MAN_BIT]);

	// Displayed period forced while sine modulation is chosen
	assign disp_period = am_sine_q ? SINE_PERIOD_US
		: 32'(steps_q * INTERNAL_TRIGGER_GENERATOR_STEP_US);

	// Generator users, free when nobody else has it
	assign share[SH_GATE_BIT] = (gate_src_q == GATE_SRC_INTERNAL_TRIGGER_GENERATOR);
	assign share[SH_FSK_BIT]  = fsk_uses_internal_trigger_generator;
	assign share[SH_AM_BIT]   = am_int_q;
	assign share[SH_TRIG_BIT] = trig_uses_internal_trigger_generator;
	assign share[SH_FREE_BIT] = ~|share[SH_TRIG_BIT:SH_GATE_BIT];

	// Clamp the requested period into range
	always_comb begin
		req_us = wdata;
		if (wdata < INTERNAL_TRIGGER_GENERATOR_MIN_US)
			req_us = INTERNAL_TRIGGER_GENERATOR_MIN_US;
		else if (wdata > INTERNAL_TRIGGER_GENERATOR_MAX_US)
			req_us = INTERNAL_TRIGGER_GENERATOR_MAX_US;
	end

	// Register writes, key toggles and read mux
	always_comb begin
		gate_en_d   = gate_en_q;
		gate_edit_d = gate_edit_q;
		gate_src_d  = gate_src_q;
		man_gate_d  = man_gate_q;
		am_en_d     = am_en_q;
		am_edit_d   = am_edit_q;
		am_int_d    = am_int_q;
		am_sine_d   = am_sine_q;
		depth_d     = depth_q;
		steps_d     = steps_q;
		rdata_d     = '0;
		if (gate_key_ev)
			gate_en_d = ~gate_en_q;
		if (am_key_ev)
			am_en_d = ~am_en_q;
		if (man_ev && gate_src_q == GATE_SRC_MAN)
			man_gate_d = ~man_gate_q;
		if (wr) begin
			case (addr)
				GCFG_OFS: begin
					gate_edit_d = wdata[GCFG_EDIT_BIT];
					case (wdata[GCFG_SRC_LSB +: 2])
						2'h0: gate_src_d = GATE_SRC_EXT;
						2'h1: gate_src_d = GATE_SRC_MAN;
						2'h2: gate_src_d = GATE_SRC_INTERNAL_TRIGGER_GENERATOR;
						default: gate_src_d = gate_src_q;
					endcase
				end
				AMCFG_OFS: begin
					am_edit_d = wdata[AM_EDIT_BIT];
					am_int_d  = wdata[AM_SRC_BIT];
					am_sine_d = wdata[AM_WAVE_BIT];
					if (wdata[AM_DEPTH_LSB +: 7] >= DEPTH_MIN
						&& wdata[AM_DEPTH_LSB +: 7] <= DEPTH_MAX)
						depth_d = wdata[AM_DEPTH_LSB +: 7];
				end
				PERIOD_OFS: begin
					steps_d = 24'((req_us + INTERNAL_TRIGGER_GENERATOR_STEP_US - 32'h0000_0001)
						/ INTERNAL_TRIGGER_GENERATOR_STEP_US);
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (addr)
				KEY_OFS:    rdata_d = {30'h0000_0000, am_en_q, gate_en_q};
				GCFG_OFS:   rdata_d = {29'h0000_0000, gate_edit_q,
					gate_src_q};
				AMCFG_OFS:  rdata_d = {17'h0_0000, depth_q, 5'h00,
					am_edit_q, am_sine_q, am_int_q};
				PERIOD_OFS: rdata_d = disp_period;
				FREQ_OFS:   rdata_d = freq_mhz;
				SHARE_OFS:  rdata_d = {27'h000_0000, share};
				STAT_OFS:   rdata_d = {29'h0000_0000, gate_cond, internal_trigger_generator_q,
					ext_s2_q};
				default:    rdata_d = '0;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			gate_en_q   <= 1'b0;
			gate_edit_q <= 1'b0;
			gate_src_q  <= GATE_SRC_EXT;
			man_gate_q  <= 1'b0;
			am_en_q     <= 1'b0;
			am_edit_q   <= 1'b0;
			am_int_q    <= 1'b0;
			am_sine_q   <= 1'b0;
			depth_q     <= DEPTH_RST;
			steps_q     <= INTERNAL_TRIGGER_GENERATOR_STEPS_RST;
			rdata_q     <= '0;
		end else begin
			gate_en_q   <= gate_en_d;
			gate_edit_q <= gate_edit_d;
			gate_src_q  <= gate_src_d;
			man_gate_q  <= man_gate_d;
			am_en_q     <= am_en_d;
			am_edit_q   <= am_edit_d;
			am_int_q    <= am_int_d;
			am_sine_q   <= am_sine_d;
			depth_q     <= depth_d;
			steps_q     <= steps_d;
			rdata_q     <= rdata_d;
		end
	end

	// Trigger generator: 10 us ticks, toggle each half period
	assign tick = (pre_q == 7'(HALF_STEP_CYC - 1));
	always_comb begin
		pre_d       = tick ? 7'h00 : pre_q + 7'h01;
		half_d      = half_q;
		internal_trigger_generator_d      = internal_trigger_generator_q;
		blink_cnt_d = blink_cnt_q + 24'h00_0001;
		blink_d     = blink_q;
		if (tick) begin
			if (half_q >= steps_q - 24'h00_0001) begin
				half_d = '0;
				internal_trigger_generator_d = ~internal_trigger_generator_q;
			end else begin
				half_d = half_q + 24'h00_0001;
			end
		end
		if (blink_cnt_q >= 24'(BLINK_CYC - 1)) begin
			blink_cnt_d = '0;
			blink_d     = ~blink_q;
		end
	end

	// Generator and blink timers
	always_ff @(posedge clk) begin
		if (rst) begin
			pre_q       <= '0;
			half_q      <= '0;
			internal_trigger_generator_q      <= 1'b0;
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else begin
			pre_q       <= pre_d;
			half_q      <= half_d;
			internal_trigger_generator_q      <= internal_trigger_generator_d;
			blink_cnt_q <= blink_cnt_d;
			blink_q     <= blink_d;
		end
	end

	// Gate pin synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
		end else begin
			ext_s1_q <= external_gate_input;
			ext_s2_q <= ext_s1_q;
		end
	end

	// Gate condition by source
	always_comb begin
		case (gate_src_q)
			GATE_SRC_EXT:  gate_cond = ext_s2_q;
			GATE_SRC_MAN:  gate_cond = man_gate_q;
			GATE_SRC_INTERNAL_TRIGGER_GENERATOR: gate_cond = internal_trigger_generator_q;
			default:       gate_cond = 1'b0;
		endcase
	end

	// Output switch and indicators; waveform is passed untouched
	always_comb begin
		out_d  = (!gate_en_q || gate_cond) ? main_wave : dc_offset;
		gind_d = gate_edit_q ? blink_q : gate_en_q;
		aind_d = am_edit_q ? blink_q : am_en_q;
	end

	// Output registers
	always_ff @(posedge clk) begin
		if (rst) begin
			out_q  <= '0;
			gind_q <= 1'b0;
			aind_q <= 1'b0;
			disp_q <= '0;
		end else begin
			out_q  <= out_d;
			gind_q <= gind_d;
			aind_q <= aind_d;
			disp_q <= disp_period;
		end
	end

	// Frequency shown beside the period, recomputed on change
	period_to_freq u_freq (
		.clk      (clk),
		.rst      (rst),
		.start    (disp_q != disp_period),
		.divisor  (disp_period),
		.quotient (freq_mhz)
	);

	assign rdata                    = rdata_q;
	assign main_out                 = out_q;
	assign gate_indicator           = gind_q;
	assign am_indicator             = aind_q;
	assign trigger_generator_output = internal_trigger_generator_q;
	assign am_enable                = am_en_q;
	assign am_internal              = am_int_q;
	assign am_sine_select           = am_sine_q;
	assign modulation_depth_setting = depth_q;
	assign am_square_mod            = internal_trigger_generator_q;

	// Checks
	property p_gate_toggle;
		@(posedge clk) disable iff (rst)
		gate_key_ev |=> gate_en_q != $past(gate_en_q);
	endproperty
	a_gate_toggle: assert property (p_gate_toggle)
		else $error("gate enable did not toggle");

	property p_gate_blink;
		@(posedge clk) disable iff (rst)
		gate_edit_q |=> gate_indicator == $past(blink_q);
	endproperty
	a_gate_blink: assert property (p_gate_blink)
		else $error("gate indicator not blinking in edit");

	property p_src_legal;
		@(posedge clk) disable iff (rst)
		gate_src_q != 2'h3;
	endproperty
	a_src_legal: assert property (p_src_legal)
		else $error("illegal gate source");

	property p_closed_offset;
		@(posedge clk) disable iff (rst)
		gate_en_q && !gate_cond |=> main_out == $past(dc_offset);
	endproperty
	a_closed_offset: assert property (p_closed_offset)
		else $error("closed gate did not show dc offset");

	property p_ext_level;
		@(posedge clk) disable iff (rst)
		gate_en_q && gate_src_q == GATE_SRC_EXT && ext_s2_q
			|=> main_out == $past(main_wave);
	endproperty
	a_ext_level: assert property (p_ext_level)
		else $error("external gate high did not pass waveform");

	property p_man_flip;
		@(posedge clk) disable iff (rst)
		man_ev && gate_src_q == GATE_SRC_MAN
			|=> man_gate_q != $past(man_gate_q);
	endproperty
	a_man_flip: assert property (p_man_flip)
		else $error("manual gate did not flip");

	property p_internal_trigger_generator_edge;
		@(posedge clk) disable iff (rst)
		$changed(internal_trigger_generator_q) |-> $past(tick);
	endproperty
	a_internal_trigger_generator_edge: assert property (p_internal_trigger_generator_edge)
		else $error("generator changed off a tick");

	property p_round_up;
		@(posedge clk) disable iff (rst)
		wr && addr == PERIOD_OFS && wdata >= INTERNAL_TRIGGER_GENERATOR_MIN_US
			&& wdata <= INTERNAL_TRIGGER_GENERATOR_MAX_US
			|=> 32'(steps_q * INTERNAL_TRIGGER_GENERATOR_STEP_US) >= $past(wdata)
			&& 32'(steps_q * INTERNAL_TRIGGER_GENERATOR_STEP_US) < $past(wdata) + INTERNAL_TRIGGER_GENERATOR_STEP_US;
	endproperty
	a_round_up: assert property (p_round_up)
		else $error("period not rounded up to next step");

	property p_free;
		@(posedge clk) disable iff (rst)
		share[SH_FREE_BIT] |-> !am_int_q && gate_src_q != GATE_SRC_INTERNAL_TRIGGER_GENERATOR;
	endproperty
	a_free: assert property (p_free)
		else $error("free shown while generator in use");

	property p_depth;
		@(posedge clk) disable iff (rst)
		depth_q >= DEPTH_MIN && depth_q <= DEPTH_MAX;
	endproperty
	a_depth: assert property (p_depth)
		else $error("depth out of range");

	property p_sine_disp;
		@(posedge clk) disable iff (rst)
		rd && addr == PERIOD_OFS && am_sine_q |=> rdata == SINE_PERIOD_US;
	endproperty
	a_sine_disp: assert property (p_sine_disp)
		else $error("sine period not forced on display");

	c_ext_gate: cover property (@(posedge clk) disable iff (rst)
		gate_en_q && gate_src_q == GATE_SRC_EXT && $rose(ext_s2_q));
	c_internal_trigger_generator_gate: cover property (@(posedge clk) disable iff (rst)
		gate_en_q && gate_src_q == GATE_SRC_INTERNAL_TRIGGER_GENERATOR && $fell(internal_trigger_generator_q));
	c_am_sine: cover property (@(posedge clk) disable iff (rst)
		am_en_q && am_int_q && am_sine_q);

endmodule

// file: core/gate_am_pkg.sv
// Constants for the gate and amplitude-modulation control block.
// Assumes a 10 MHz system clock and a plain register port.
package gate_am_pkg;

	// Clock and internal trigger generator timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned HALF_STEP_NS  = 10_000;
	localparam int unsigned HALF_STEP_CYC = HALF_STEP_NS / CLK_PERIOD_NS;
	localparam int unsigned BLINK_MS      = 250;
	localparam int unsigned BLINK_CYC_DEF = BLINK_MS * (CLK_HZ / 1000);

	// Generator period limits and steps, in microseconds
	localparam logic [31:0] INTERNAL_TRIGGER_GENERATOR_STEP_US   = 32'h0000_0014;
	localparam logic [31:0] INTERNAL_TRIGGER_GENERATOR_MIN_US    = 32'h0000_0014;
	localparam logic [31:0] INTERNAL_TRIGGER_GENERATOR_MAX_US    = 32'h0BEB_C200;
	localparam logic [31:0] SINE_PERIOD_US = 32'h0000_03E8;
	localparam logic [23:0] INTERNAL_TRIGGER_GENERATOR_STEPS_RST = 24'h00_0032;
	localparam logic [31:0] FREQ_DIVIDEND  = 32'h3B9A_CA00;

	// Modulation depth in percent
	localparam logic [6:0] DEPTH_MIN = 7'h01;
	localparam logic [6:0] DEPTH_MAX = 7'h64;
	localparam logic [6:0] DEPTH_RST = 7'h1E;

	// Register byte offsets
	localparam logic [7:0] KEY_OFS    = 8'h00;
	localparam logic [7:0] GCFG_OFS   = 8'h04;
	localparam logic [7:0] AMCFG_OFS  = 8'h08;
	localparam logic [7:0] PERIOD_OFS = 8'h0C;
	localparam logic [7:0] FREQ_OFS   = 8'h10;
	localparam logic [7:0] SHARE_OFS  = 8'h14;
	localparam logic [7:0] STAT_OFS   = 8'h18;

	// Field positions
	localparam int unsigned KEY_GATE_BIT  = 0;
	localparam int unsigned KEY_AM_BIT    = 1;
	localparam int unsigned KEY_MAN_BIT   = 2;
	localparam int unsigned GCFG_SRC_LSB  = 0;
	localparam int unsigned GCFG_EDIT_BIT = 2;
	localparam int unsigned AM_SRC_BIT    = 0;
	localparam int unsigned AM_WAVE_BIT   = 1;
	localparam int unsigned AM_EDIT_BIT   = 2;
	localparam int unsigned AM_DEPTH_LSB  = 8;
	localparam int unsigned SH_GATE_BIT   = 0;
	localparam int unsigned SH_FSK_BIT    = 1;
	localparam int unsigned SH_AM_BIT     = 2;
	localparam int unsigned SH_TRIG_BIT   = 3;
	localparam int unsigned SH_FREE_BIT   = 4;

	// Gate source choices
	typedef enum logic [1:0] {
		GATE_SRC_EXT,
		GATE_SRC_MAN,
		GATE_SRC_INTERNAL_TRIGGER_GENERATOR
	} gate_src_e;

endpackage

// file: core/period_to_freq.sv
// Serial divider turning a period in microseconds into millihertz.
// Assumes the divisor is never zero and stays put while busy.
`timescale 1ns/100ps
module period_to_freq
	import gate_am_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [31:0] divisor,
	output logic      [31:0] quotient
);

	logic [32:0] rem_q,  rem_d;
	logic [31:0] quo_q,  quo_d;
	logic [31:0] res_q,  res_d;
	logic [5:0]  cnt_q,  cnt_d;
	logic        busy_q, busy_d;
	logic [32:0] trial;

	// One quotient bit per cycle, restart on request
	always_comb begin
		rem_d  = rem_q;
		quo_d  = quo_q;
		res_d  = res_q;
		cnt_d  = cnt_q;
		busy_d = busy_q;
		trial  = {rem_q[31:0], quo_q[31]};
		if (start) begin
			rem_d  = '0;
			quo_d  = FREQ_DIVIDEND;
			cnt_d  = 6'h20;
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (trial >= {1'b0, divisor}) begin
				rem_d = trial - {1'b0, divisor};
				quo_d = {quo_q[30:0], 1'b1};
			end else begin
				rem_d = trial;
				quo_d = {quo_q[30:0], 1'b0};
			end
			cnt_d = cnt_q - 6'h01;
			if (cnt_q == 6'h01) begin
				busy_d = 1'b0;
				res_d  = quo_d;
			end
		end
	end

	// Divider state
	always_ff @(posedge clk) begin
		if (rst) begin
			rem_q  <= '0;
			quo_q  <= '0;
			res_q  <= '0;
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end else begin
			rem_q  <= rem_d;
			quo_q  <= quo_d;
			res_q  <= res_d;
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign quotient = res_q;

endmodule

// file: dv/panel_model.sv
// Front panel keys, other generator users and gate pin seen by the control block.
// Assumes one clock; key events are one-cycle pulses after a rising edge.
`timescale 1ns/100ps
module panel_model (
	input  wire logic clk,
	output logic      gate_key_press,
	output logic      am_key_press,
	output logic      manual_trigger_key,
	output logic      external_gate_input,
	output logic      fsk_uses_internal_trigger_generator,
	output logic      trig_uses_internal_trigger_generator
);
	// Idle levels at time zero
	initial begin
		gate_key_press = 1'b0;
		am_key_press = 1'b0;
		manual_trigger_key = 1'b0;
		external_gate_input = 1'b0;
		fsk_uses_internal_trigger_generator = 1'b0;
		trig_uses_internal_trigger_generator = 1'b0;
	end

	// One-cycle key pulse: 0 gate, 1 modulation, 2 manual
	task automatic press(input int k);
		@(posedge clk);
		gate_key_press <= (k == 0);
		am_key_press <= (k == 1);
		manual_trigger_key <= (k == 2);
		@(posedge clk);
		gate_key_press <= 1'b0;
		am_key_press <= 1'b0;
		manual_trigger_key <= 1'b0;
	endtask

	// Gate pin level, already squared against the threshold
	task automatic set_ext(input logic v);
		@(posedge clk);
		external_gate_input <= v;
	endtask

	// Other functions claiming the generator
	task automatic set_users(input logic f, input logic t);
		@(posedge clk);
		fsk_uses_internal_trigger_generator <= f;
		trig_uses_internal_trigger_generator <= t;
	endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the gate and modulation control block.
// Assumes the panel model on the key side and a plain register port.
`timescale 1ns/100ps
module testbench;
	import gate_am_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        gk, ak, mk, ext, fu, tu;
	logic [11:0] main_wave;
	logic [11:0] dc_offset;
	logic [11:0] main_out, wave_q, dc_q;
	logic        gate_ind, am_ind, gen, am_en, am_int, am_sine, am_sq;
	logic [6:0]  depth;
	logic [31:0] seed = 32'h0000_0005;
	logic [31:0] r, v, p;
	int          errors = 0;
	int          checks = 0;
	int          n;

	gate_am_ctrl #(.BLINK_CYC(8)) u_dut (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_key_press(gk),
		.am_key_press(ak), .manual_trigger_key(mk), .external_gate_input(ext),
		.fsk_uses_internal_trigger_generator(fu), .trig_uses_internal_trigger_generator(tu), .main_wave(main_wave),
		.dc_offset(dc_offset), .main_out(main_out), .gate_indicator(gate_ind),
		.am_indicator(am_ind), .trigger_generator_output(gen),
		.am_enable(am_en), .am_internal(am_int), .am_sine_select(am_sine),
		.modulation_depth_setting(depth), .am_square_mod(am_sq));
	panel_model u_panel (.clk(clk), .gate_key_press(gk), .am_key_press(ak),
		.manual_trigger_key(mk), .external_gate_input(ext),
		.fsk_uses_internal_trigger_generator(fu), .trig_uses_internal_trigger_generator(tu));

	// Clock, 100 ns period
	initial begin
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Period the generator should accept for a request
	function automatic logic [31:0] exp_per(input logic [31:0] x);
		if (x < INTERNAL_TRIGGER_GENERATOR_MIN_US) return INTERNAL_TRIGGER_GENERATOR_MIN_US;
		if (x > INTERNAL_TRIGGER_GENERATOR_MAX_US) return INTERNAL_TRIGGER_GENERATOR_MAX_US;
		return ((x + 32'h0000_0013) / INTERNAL_TRIGGER_GENERATOR_STEP_US) * INTERNAL_TRIGGER_GENERATOR_STEP_US;
	endfunction

	// Free-running waveform and offset, with last-cycle copies
	always @(posedge clk) begin
		r = rnd();
		wave_q <= main_wave;
		dc_q <= dc_offset;
		main_wave <= r[11:0];
		dc_offset <= r[27:16];
	end

	task automatic results();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Main output after the next edge, open gate or dc offset
	task automatic chk_out(input logic open);
		@(posedge clk);
		#1;
		chk({20'h0, main_out}, {20'h0, open ? wave_q : dc_q}, "main_out");
	endtask

	task automatic wait_gen(input logic lv);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (gen !== lv && n < 20000);
		if (gen !== lv) begin
			errors++;
			$display("CHECK FAILED t=%0t generator level timeout", $time);
		end
	endtask

	// Ones seen on an indicator over 24 cycles
	task automatic blink(input logic am, input string m);
		n = 0;
		repeat (24) begin
			@(posedge clk);
			#1;
			if ((am ? am_ind : gate_ind) === 1'b1) n++;
		end
		chk({31'h0, n >= 8 && n <= 16}, 32'h1, m);
	endtask

	// Watchdog
	initial begin
		#6_000_000;
		errors++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		results();
	end

	// Test sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd_reg(GCFG_OFS, v);
		chk(v, 32'h0, "gcfg reset");
		rd_reg(AMCFG_OFS, v);
		chk(v, 32'h0000_1E00, "amcfg reset");
		rd_reg(PERIOD_OFS, v);
		chk(v, 32'h0000_03E8, "period reset");
		rd_reg(SHARE_OFS, v);
		chk(v, 32'h0000_0010, "share free");
		rd_reg(8'h1C, v);
		chk(v, 32'h0, "unmapped");
		u_panel.press(0);
		rd_reg(KEY_OFS, v);
		chk(v, 32'h1, "gate enable");
		chk({31'h0, gate_ind}, 32'h1, "gate lamp");
		chk_out(0);
		u_panel.set_ext(1'b1);
		chk_out(0);
		chk_out(0);
		repeat (12) chk_out(1);
		rd_reg(STAT_OFS, v);
		chk(v, 32'h0000_0005, "status");
		wr_reg(GCFG_OFS, 32'h4);
		blink(1'b0, "gate blink");
		wr_reg(GCFG_OFS, 32'h1);
		chk_out(0);
		u_panel.set_ext(1'b0);
		u_panel.press(2);
		chk_out(1);
		wr_reg(KEY_OFS, 32'h4);
		chk_out(0);
		wr_reg(GCFG_OFS, 32'h3);
		rd_reg(GCFG_OFS, v);
		chk(v, 32'h1, "gcfg code 3");
		for (int i = 0; i < 11; i++) begin
			p = (i < 5) ? rnd() & 32'h0000_3FFF : rnd();
			if (i == 5) p = 32'h0000_006D;
			if (i == 6) p = 32'h0000_0005;
			if (i == 7) p = 32'h0BEB_C201;
			if (i == 8) p = 32'hFFFF_FFFF;
			if (i == 9) p = 32'h0000_0014;
			if (i == 10) p = 32'h0000_001E;
			wr_reg(PERIOD_OFS, p);
			rd_reg(PERIOD_OFS, v);
			chk(v, exp_per(p), "period round");
		end
		wr_reg(GCFG_OFS, 32'h2);
		wait_gen(1);
		wait_gen(0);
		wait_gen(1);
		wait_gen(0);
		chk(n, 32'd200, "half period");
		repeat (3) @(posedge clk);
		chk_out(0);
		wait_gen(1);
		repeat (3) @(posedge clk);
		chk_out(1);
		chk({31'h0, am_sq}, {31'h0, gen}, "square mod");
		rd_reg(FREQ_OFS, v);
		chk(v, 32'h017D_7840, "freq");
		wr_reg(FREQ_OFS, 32'h0);
		rd_reg(FREQ_OFS, v);
		chk(v, 32'h017D_7840, "freq ro");
		for (int i = 0; i < 16; i++) begin
			wr_reg(GCFG_OFS, i[0] ? 32'h2 : 32'h1);
			wr_reg(AMCFG_OFS, {17'h0, DEPTH_RST, 7'h0, 1'(i[2])});
			u_panel.set_users(i[1], i[3]);
			rd_reg(SHARE_OFS, v);
			chk(v, {27'h0, i[3:0] == 4'h0, i[3:0]}, "share");
			chk({31'h0, am_int}, {31'h0, i[2]}, "am source");
		end
		u_panel.press(1);
		#1;
		chk({31'h0, am_en}, 32'h1, "am enable");
		@(posedge clk);
		#1;
		chk({31'h0, am_ind}, 32'h1, "am lamp");
		wr_reg(AMCFG_OFS, 32'h0000_1E03);
		rd_reg(PERIOD_OFS, v);
		chk(v, SINE_PERIOD_US, "sine period");
		chk({31'h0, am_sine}, 32'h1, "sine select");
		repeat (40) @(posedge clk);
		rd_reg(FREQ_OFS, v);
		chk(v, 32'h000F_4240, "sine freq");
		wr_reg(AMCFG_OFS, 32'h0000_1E01);
		rd_reg(PERIOD_OFS, v);
		chk(v, exp_per(32'h0000_001E), "period kept");
		for (int i = 0; i < 4; i++) begin
			p = (i == 0) ? 32'd100 : (i == 1) ? 32'd0 : (i == 2) ? 32'd101 : 32'd1;
			wr_reg(AMCFG_OFS, {17'h0, p[6:0], 8'h01});
			@(posedge clk);
			#1;
			chk({25'h0, depth}, (i < 3) ? 32'd100 : 32'd1, "depth");
		end
		wr_reg(AMCFG_OFS, 32'h0000_0104);
		blink(1'b1, "am blink");
		results();
	end
endmodule
